/* hdl/acq_dma_pkg.sv */
package acq_dma_pkg;
    timeunit 1ns;
    timeprecision 1ns;
    // Register indices; the byte address is four times the index.
    localparam logic [17:0] CMD_IDX = 18'h00064;
    localparam logic [17:0] STAT_IDX = 18'h0006e;
    localparam logic [17:0] MODE_IDX = 18'h0251c;
    localparam logic [17:0] MEMSIZE_IDX = 18'h02710;
    localparam logic [17:0] POST_IDX = 18'h02774;
    localparam logic [17:0] MEMTEST_IDX = 18'h30ffc;
    localparam logic [17:0] NOTIFY_IDX = 18'h0012c;
    localparam logic [17:0] OFFS_IDX = 18'h0012d;
    localparam logic [17:0] LEN_IDX = 18'h0012e;
    localparam logic [17:0] DIR_IDX = 18'h0012f;
    localparam logic [17:0] DEFBUF_IDX = 18'h00130;
    localparam logic [17:0] TMO_IDX = 18'h00131;
    localparam logic [17:0] CHAN_IDX = 18'h00132;
    // Command word bits.
    localparam int CMD_CARD_START = 2;
    localparam int CMD_CARD_STOP = 6;
    localparam int CMD_XFER_START = 16;
    localparam int CMD_XFER_WAIT = 17;
    localparam int CMD_XFER_STOP = 18;
    // Status word bits.
    localparam int ST_RUN = 0;
    localparam int ST_ARMED = 1;
    localparam int ST_TRIG = 2;
    localparam int ST_ACQ_DONE = 3;
    localparam int ST_BLOCK = 8;
    localparam int ST_DONE = 9;
    localparam int ST_OVERRUN = 10;
    localparam int ST_FAULT = 11;
    localparam int ST_TIMEOUT = 12;
    // Field values and reset values.
    localparam logic [31:0] MODE_SINGLE = 32'h00000001;
    localparam logic [31:0] RST_MODE = 32'h00000001;
    localparam logic [31:0] RST_MEMSIZE = 32'h00000040;
    localparam logic [31:0] RST_POST = 32'h00000020;
    localparam logic [31:0] RST_ZERO = 32'h00000000;
    localparam logic DIR_TO_HOST = 1'b1;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // On-board memory.
    localparam int MEM_AW = 8;
    localparam int MEM_DEPTH = 256;
    localparam logic [8:0] MEM_SAMPLES = 9'h100;
    localparam logic [31:0] MEM_BYTES = 32'h00000200;
    localparam logic [31:0] BYTES_PER_SAMPLE = 32'h00000002;
    // Timing.
    localparam int CLK_PERIOD_NS = 100;
    localparam int TMO_UNIT_NS = 1000000;
    localparam int TMO_UNIT_CYC_DEF = TMO_UNIT_NS / CLK_PERIOD_NS;
    localparam logic [7:0] SAMPLE_DIV = 8'h0a;

    typedef enum logic [2:0] {
        acq_idle, acq_fill, acq_armed, acq_post, acq_done
    } acq_state_type;

    typedef enum logic [1:0] {
        dma_idle, dma_hold, dma_run
    } dma_state_type;
endpackage

/* hdl/acquisition_dma_control.sv */
// Operation
// (R01) Write-only command word at index 100.
// (R02) Card and transfer bits execute together.
// (R03) Transfer start bit begins defined buffer.
// (R04) Transfer start held off until trigger. The code holds it until recording ends, after the post samples.
// (R05) Wait blocks until done, block, timeout.
// (R06) Transfer stop aborts, buffer becomes invalid.
// (R07) Read-only status word at index 110.
// (R08) Block ready when notify bytes available.
// (R09) Done flag only with zero notify.
// (R10) Overrun flag on overwritten transfer data.
// (R11) Fault flag on internal transfer error.
// (R12) Host stops transfer before freeing buffer.
// (R13) Equidistant sampling without host involvement.
// (R14) Ring buffer recording until trigger.
// (R15) Record exact post count, then stop.
// (R16) Trigger disarmed until pretrigger filled.
// (R17) Mode register readable, value one single.
// (R18) Memory size register holds total samples.
// (R19) Post register holds samples after trigger.
// (R20) Pretrigger equals memory size minus post.
// (R21) Size bounded by memory and channels.
// (R22) Notify pulse per block or at end.
// (R23) Direction must match mode or memtest.
// (R24) Buffer invalidated when transfer ends.
// (R25) Card reads ascend from board offset.
//
// Added by the designer: the AXI4-Lite register port.
module acquisition_dma_control
    import acq_dma_pkg::*;
#(
    parameter int TMO_UNIT_CYC = TMO_UNIT_CYC_DEF
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [19:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [19:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic trigger_in,
    input wire logic [15:0] sample_data,
    output logic [31:0] host_wr_data,
    output logic host_wr_valid,
    input wire logic host_wr_ready,
    input wire logic [31:0] host_rd_data,
    input wire logic host_rd_valid,
    output logic host_rd_ready,
    output logic xfer_notify
);
    timeunit 1ns;
    timeprecision 1ns;
    function automatic logic [31:0] lanes(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] s);
        return (old & ~lanes(s)) | (nw & lanes(s));
    endfunction

    logic aw_hold_q, w_hold_q, wait_q, rvalid_q, bvalid_q;
    logic [19:0] aw_addr_q;
    logic [31:0] w_data_q, rdata_q;
    logic [3:0] w_strb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] mode_q, memsize_q, post_q, notify_q, offs_q, len_q;
    logic [31:0] tmo_q, tmo_cyc_q, tmo_ms_q, left_q, blk_q;
    logic [1:0] chan_q;
    logic dir_q, memtest_q, bufv_q;
    logic blk_flag_q, done_flag_q, ovr_flag_q, fault_flag_q, tmo_flag_q;
    logic trig_seen_q, out_valid_q, notify_q1;
    logic [31:0] out_data_q;
    logic [7:0] div_q, wr_ptr_q, rd_q;
    logic [8:0] cnt_q;
    logic [15:0] mem_q [MEM_DEPTH];
    acq_state_type acq_q;
    dma_state_type dma_q;

    // Register bus decode.
    wire [17:0] widx = aw_addr_q[19:2];
    wire [17:0] ridx = araddr[19:2];
    wire wr_go = aw_hold_q & w_hold_q & ~bvalid_q & ~wait_q;
    wire [31:0] wm = merge(RST_ZERO, w_data_q, w_strb_q);
    wire wr_ok = widx == CMD_IDX || widx == MODE_IDX ||
        widx == MEMSIZE_IDX || widx == POST_IDX ||
        widx == MEMTEST_IDX || widx == NOTIFY_IDX ||
        widx == OFFS_IDX || widx == LEN_IDX || widx == DIR_IDX ||
        widx == DEFBUF_IDX || widx == TMO_IDX || widx == CHAN_IDX;
    wire cmd_wr = wr_go & (widx == CMD_IDX);
    // (R02) all bits act
    wire card_start = cmd_wr & wm[CMD_CARD_START] & ~memtest_q &
        (mode_q == MODE_SINGLE);
    wire card_stop = cmd_wr & wm[CMD_CARD_STOP] & ~memtest_q;
    wire x_start = cmd_wr & wm[CMD_XFER_START] & (dma_q == dma_idle);
    wire x_wait = cmd_wr & wm[CMD_XFER_WAIT];
    wire x_stop = cmd_wr & wm[CMD_XFER_STOP];

    // (R21) memory and channel bound
    wire [8:0] lim = MEM_SAMPLES >> chan_q;
    wire [8:0] eff_len = (|memsize_q[31:9] || memsize_q[8:0] > lim) ?
        lim : memsize_q[8:0];
    wire [8:0] post_eff = (|post_q[31:9] || post_q[8:0] > eff_len) ?
        eff_len : post_q[8:0];
    // (R20) pretrigger from size
    wire [8:0] pre_len = eff_len - post_eff;

    // (R13) free running sample tick
    wire tick = div_q == SAMPLE_DIV - 8'h01;
    wire recording = acq_q == acq_fill || acq_q == acq_armed ||
        acq_q == acq_post;
    wire acq_we = tick & recording;
    wire [7:0] ptr_nx = wr_ptr_q + 8'h01;
    wire ptr_wrap = {1'b0, ptr_nx} == eff_len;

    // (R23) direction against mode
    wire dir_bad = dir_q == DIR_TO_HOST ?
        (~memtest_q & (mode_q != MODE_SINGLE)) : ~memtest_q;
    wire range_bad = (len_q == RST_ZERO) ||
        ({1'b0, offs_q} + {1'b0, len_q} > {1'b0, MEM_BYTES});
    // (R11) refused start faults
    wire start_bad = x_start & (~bufv_q | dir_bad | range_bad);
    wire start_ok = x_start & ~start_bad;

    wire running = dma_q == dma_run;
    wire to_host = dir_q == DIR_TO_HOST;
    wire out_free = ~out_valid_q | host_wr_ready;
    wire out_load = running & to_host & out_free & (left_q != RST_ZERO);
    wire host_take = host_rd_valid & host_rd_ready;
    wire acc = (out_valid_q & host_wr_ready) | host_take;
    wire left_end = left_q <= BYTES_PER_SAMPLE;
    wire [31:0] left_nx = left_end ? RST_ZERO : left_q - BYTES_PER_SAMPLE;
    wire xfer_end = running & (left_q == RST_ZERO) &
        (to_host ? ~out_valid_q | host_wr_ready : 1'b1);
    wire [31:0] blk_sum = blk_q + BYTES_PER_SAMPLE;
    wire blk_hit = acc & (notify_q != RST_ZERO) & (blk_sum >= notify_q);
    // (R22) notify pulse source
    wire notify_ev = blk_hit | (xfer_end & (notify_q == RST_ZERO));

    wire tmo_tick = tmo_cyc_q == TMO_UNIT_CYC - 1;
    wire tmo_hit = wait_q & (tmo_q != RST_ZERO) & (tmo_ms_q == tmo_q);
    // (R05) wait release condition
    wire wait_done = (dma_q == dma_idle) | blk_flag_q | tmo_hit;

    // (R10) memory overwritten mid transfer
    wire ovr_set = acq_we & running & to_host;

    wire mem_we = acq_we | host_take;
    wire [7:0] mem_wa = acq_we ? wr_ptr_q : rd_q;
    wire [15:0] mem_wd = acq_we ? sample_data : host_rd_data[15:0];

    // (R07) read-only status assembly
    wire [31:0] status = {19'h0, tmo_flag_q, fault_flag_q, ovr_flag_q,
        done_flag_q, blk_flag_q, 4'h0, acq_q == acq_done,
        acq_q == acq_post, acq_q == acq_armed, recording};
    wire [31:0] rd_mux =
        ridx == STAT_IDX ? status :
        ridx == MODE_IDX ? mode_q :
        ridx == MEMSIZE_IDX ? memsize_q :
        ridx == POST_IDX ? post_q :
        ridx == MEMTEST_IDX ? {31'h0, memtest_q} :
        ridx == NOTIFY_IDX ? notify_q :
        ridx == OFFS_IDX ? offs_q :
        ridx == LEN_IDX ? len_q :
        ridx == DIR_IDX ? {31'h0, dir_q} :
        ridx == DEFBUF_IDX ? {31'h0, bufv_q} :
        ridx == TMO_IDX ? tmo_q :
        ridx == CHAN_IDX ? {30'h0, chan_q} : RST_ZERO;
    // (R01) command word not readable
    wire rd_ok = ridx != CMD_IDX && (rd_mux != RST_ZERO ||
        ridx == STAT_IDX || ridx == MODE_IDX || ridx == MEMSIZE_IDX ||
        ridx == POST_IDX || ridx == MEMTEST_IDX || ridx == NOTIFY_IDX ||
        ridx == OFFS_IDX || ridx == LEN_IDX || ridx == DIR_IDX ||
        ridx == DEFBUF_IDX || ridx == TMO_IDX || ridx == CHAN_IDX);

    assign awready = ~aw_hold_q;
    assign wready = ~w_hold_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = ~rvalid_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign host_wr_valid = out_valid_q;
    assign host_wr_data = out_data_q;
    assign host_rd_ready = running & ~to_host & (left_q != RST_ZERO);
    assign xfer_notify = notify_q1;

    // Write channel capture and response.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= 20'h00000;
            w_data_q <= RST_ZERO;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            wait_q <= 1'b0;
        end
        else
        begin
            if (awvalid & ~aw_hold_q)
            begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid & ~w_hold_q)
            begin
                w_hold_q <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (wr_go)
            begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
                // (R05) hold response while waiting
                wait_q <= x_wait;
                bvalid_q <= ~x_wait;
            end
            else if (wait_q & wait_done)
            begin
                wait_q <= 1'b0;
                bvalid_q <= 1'b1;
            end
            else if (bvalid_q & bready)
                bvalid_q <= 1'b0;
        end
    end

    // Read channel.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= RST_ZERO;
            rresp_q <= RESP_OKAY;
        end
        else if (arvalid & ~rvalid_q)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_q & rready)
            rvalid_q <= 1'b0;
    end

    // Configuration registers.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            // (R17) single mode at reset
            mode_q <= RST_MODE;
            memsize_q <= RST_MEMSIZE;
            post_q <= RST_POST;
            notify_q <= RST_ZERO;
            offs_q <= RST_ZERO;
            len_q <= RST_ZERO;
            tmo_q <= RST_ZERO;
            chan_q <= 2'b00;
            dir_q <= DIR_TO_HOST;
            memtest_q <= 1'b0;
        end
        else if (wr_go)
        begin
            if (widx == MODE_IDX)
                mode_q <= merge(mode_q, w_data_q, w_strb_q);
            // (R18) total sample count
            if (widx == MEMSIZE_IDX)
                memsize_q <= merge(memsize_q, w_data_q, w_strb_q);
            // (R19) post trigger count
            if (widx == POST_IDX)
                post_q <= merge(post_q, w_data_q, w_strb_q);
            if (widx == NOTIFY_IDX)
                notify_q <= merge(notify_q, w_data_q, w_strb_q);
            if (widx == OFFS_IDX)
                offs_q <= merge(offs_q, w_data_q, w_strb_q);
            if (widx == LEN_IDX)
                len_q <= merge(len_q, w_data_q, w_strb_q);
            if (widx == TMO_IDX)
                tmo_q <= merge(tmo_q, w_data_q, w_strb_q);
            if (widx == CHAN_IDX && w_strb_q[0])
                chan_q <= w_data_q[1:0] == 2'b11 ? 2'b10 : w_data_q[1:0];
            if (widx == DIR_IDX && w_strb_q[0])
                dir_q <= w_data_q[0];
            if (widx == MEMTEST_IDX && w_strb_q[0])
                memtest_q <= w_data_q[0];
        end
    end

    // Wait timeout counter in millisecond units.
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !wait_q)
        begin
            tmo_cyc_q <= RST_ZERO;
            tmo_ms_q <= RST_ZERO;
        end
        else
        begin
            tmo_cyc_q <= tmo_tick ? RST_ZERO : tmo_cyc_q + 32'h1;
            if (tmo_tick)
                tmo_ms_q <= tmo_ms_q + 32'h1;
        end
    end

    // Acquisition sequencer.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            acq_q <= acq_idle;
            div_q <= 8'h00;
            wr_ptr_q <= 8'h00;
            cnt_q <= 9'h000;
            trig_seen_q <= 1'b0;
        end
        else
        begin
            div_q <= tick ? 8'h00 : div_q + 8'h01;
            if (acq_we)
                // (R14) ring wraps at size
                wr_ptr_q <= ptr_wrap ? 8'h00 : ptr_nx;
            if (card_stop)
                acq_q <= acq_idle;
            else if (card_start)
            begin
                // (R16) disarmed while filling
                acq_q <= pre_len == 9'h000 ? acq_armed : acq_fill;
                wr_ptr_q <= 8'h00;
                cnt_q <= 9'h000;
                trig_seen_q <= 1'b0;
            end
            else
            begin
                unique case (acq_q)
                    acq_idle, acq_done:
                        cnt_q <= 9'h000;
                    acq_fill:
                        if (tick)
                        begin
                            cnt_q <= cnt_q + 9'h001;
                            if (cnt_q + 9'h001 == pre_len)
                                acq_q <= acq_armed;
                        end
                    acq_armed:
                        if (trigger_in)
                        begin
                            trig_seen_q <= 1'b1;
                            cnt_q <= 9'h000;
                            acq_q <= post_eff == 9'h000 ?
                                acq_done : acq_post;
                        end
                    acq_post:
                        // (R15) exact post count
                        if (tick)
                        begin
                            cnt_q <= cnt_q + 9'h001;
                            if (cnt_q + 9'h001 == post_eff)
                                acq_q <= acq_done;
                        end
                endcase
            end
        end
    end

    // On-board sample memory.
    always_ff @(posedge aclk)
    begin
        if (mem_we)
            mem_q[mem_wa] <= mem_wd;
    end

    // Transfer engine.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dma_q <= dma_idle;
            bufv_q <= 1'b0;
            rd_q <= 8'h00;
            left_q <= RST_ZERO;
            blk_q <= RST_ZERO;
            out_valid_q <= 1'b0;
            out_data_q <= RST_ZERO;
            notify_q1 <= 1'b0;
        end
        else
        begin
            notify_q1 <= notify_ev;
            if (wr_go && widx == DEFBUF_IDX && w_strb_q[0])
                bufv_q <= w_data_q[0];
            if (out_valid_q & host_wr_ready)
                out_valid_q <= 1'b0;
            if (acc)
                blk_q <= blk_hit ? blk_sum - notify_q : blk_sum;
            if (x_stop)
            begin
                // (R06) abort and invalidate
                dma_q <= dma_idle;
                bufv_q <= 1'b0;
                left_q <= RST_ZERO;
            end
            else if (start_ok)
            begin
                // (R03) start defined buffer
                // (R25) ascend from board offset
                rd_q <= offs_q[8:1];
                left_q <= len_q;
                blk_q <= RST_ZERO;
                // (R04) hold while recording
                dma_q <= (to_host & ~memtest_q &
                    (recording | card_start)) ? dma_hold : dma_run;
            end
            else
            begin
                unique case (dma_q)
                    dma_idle:
                        left_q <= RST_ZERO;
                    dma_hold:
                        if (~recording)
                            dma_q <= dma_run;
                    dma_run:
                    begin
                        if (out_load)
                        begin
                            out_valid_q <= 1'b1;
                            out_data_q <= {16'h0000, mem_q[rd_q]};
                        end
                        if (out_load | host_take)
                        begin
                            rd_q <= rd_q + 8'h01;
                            left_q <= left_nx;
                        end
                        if (xfer_end)
                        begin
                            // (R24) one-shot buffer
                            dma_q <= dma_idle;
                            bufv_q <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    // Sticky status flags; a set wins over a clear.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            blk_flag_q <= 1'b0;
            done_flag_q <= 1'b0;
            ovr_flag_q <= 1'b0;
            fault_flag_q <= 1'b0;
            tmo_flag_q <= 1'b0;
        end
        else
        begin
            // (R08) block ready flag
            blk_flag_q <= blk_hit | (blk_flag_q & ~x_wait & ~start_ok);
            // (R09) done only zero notify
            done_flag_q <= (xfer_end & (notify_q == RST_ZERO)) |
                (done_flag_q & ~start_ok);
            ovr_flag_q <= ovr_set | (ovr_flag_q & ~start_ok);
            // (R11) internal fault flag
            fault_flag_q <= start_bad | (fault_flag_q & ~start_ok);
            tmo_flag_q <= tmo_hit | (tmo_flag_q & ~x_wait);
        end
    end
endmodule

/* sim/acq_dma_properties.sv */
module acq_dma_properties
    import acq_dma_pkg::*;
#(
    parameter int TMO_UNIT_CYC = 10
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [19:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [31:0] host_wr_data,
    input wire logic host_wr_valid,
    input wire logic host_wr_ready,
    input wire logic xfer_notify
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_rd_lat;
        arvalid && arready |=> rvalid;
    endproperty
    a_rd_lat: assert property (p_rd_lat)
        else $error("read answer late");
    property p_r_once;
        rvalid && rready |=> !rvalid;
    endproperty
    a_r_once: assert property (p_r_once)
        else $error("read answer repeated");
    property p_b_once;
        bvalid && bready |=> !bvalid;
    endproperty
    a_b_once: assert property (p_b_once)
        else $error("write answer repeated");
    property p_ar_busy;
        rvalid |-> !arready;
    endproperty
    a_ar_busy: assert property (p_ar_busy)
        else $error("read taken while busy");
    property p_cmd_rd;
        arvalid && arready && araddr == {CMD_IDX, 2'b00}
            |=> rresp == RESP_SLVERR && rdata == 32'h0;
    endproperty
    a_cmd_rd: assert property (p_cmd_rd)
        else $error("command word readable");
    property p_st_rd;
        arvalid && arready && araddr == {STAT_IDX, 2'b00}
            |=> rresp == RESP_OKAY;
    endproperty
    a_st_rd: assert property (p_st_rd)
        else $error("status read refused");
    property p_beat_hold;
        host_wr_valid && !host_wr_ready
            |=> host_wr_valid && $stable(host_wr_data);
    endproperty
    a_beat_hold: assert property (p_beat_hold)
        else $error("beat dropped while stalled");
    property p_notify;
        xfer_notify |=> !xfer_notify;
    endproperty
    a_notify: assert property (p_notify)
        else $error("notify pulse too long");
endmodule

/* sim/host_stream_model.sv */
module host_stream_model
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] host_wr_data,
    input wire logic host_wr_valid,
    input wire logic [15:0] sample_data,
    output logic host_wr_ready,
    output logic [31:0] host_rd_data,
    output logic host_rd_valid,
    output logic [15:0] beats,
    output logic [15:0] bad
);
    timeunit 1ns;
    timeprecision 1ns;
    assign host_rd_valid = 1'b0;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            host_wr_ready <= 1'b0;
            host_rd_data <= 32'h0f0f0f0f;
            beats <= 16'h0;
            bad <= 16'h0;
        end
        else
        begin
            host_rd_data <= ~host_rd_data;
            host_wr_ready <= 1'($urandom_range(1, 0));
            if (host_wr_valid && host_wr_ready)
            begin
                beats <= beats + 16'h1;
                if (host_wr_data[15:0] !== sample_data)
                    bad <= bad + 16'h1;
            end
        end
    end
endmodule

/* sim/tb_acquisition_dma_control.sv */
module tb_acquisition_dma_control;
    import acq_dma_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 0, aresetn = 0, trigger_in = 0;
    logic [19:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rdata, host_wr_data, host_rd_data, d, n;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, xfer_notify;
    logic host_wr_valid, host_wr_ready, host_rd_valid, host_rd_ready;
    logic [15:0] sample_data = 0, beats, bad;
    logic [31:0] model [int];
    int miscompares = 0, checked = 0, cyc = 0, pulses = 0;
    acquisition_dma_control #(.TMO_UNIT_CYC(10))
        acquisition_dma_control_i (.*);
    host_stream_model host_stream_model_i (.*);
    always #50 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (xfer_notify === 1'b1)
            pulses <= pulses + 1;
        if (cyc == 30000)
        begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        checked++;
        if (g !== e)
        begin
            $display("[ERR] %s exp %h got %h", s, e, g);
            miscompares++;
        end
    endtask
    task automatic wr(input logic [17:0] i, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= {i, 2'b00};
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [17:0] i);
        @(posedge aclk);
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic rc(input string s, input logic [17:0] i,
        input logic [31:0] e);
        rd(i);
        chk(s, e, d);
    endtask
    initial
    begin
        n = $urandom(32'hfd12);
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        model[MODE_IDX] = RST_MODE;
        model[POST_IDX] = 32'($urandom_range(63, 1));
        rc("mode", MODE_IDX, model[MODE_IDX]);
        rc("memsize", MEMSIZE_IDX, RST_MEMSIZE);
        rc("post", POST_IDX, RST_POST);
        wr(POST_IDX, model[POST_IDX]);
        rc("post", POST_IDX, model[POST_IDX]);
        rc("cmd", CMD_IDX, 32'h0);
        chk("rresp", 32'(RESP_SLVERR), 32'(r));
        wr(STAT_IDX, 32'hffffffff);
        chk("bresp", 32'(RESP_SLVERR), 32'(r));
        n = 2 * $urandom_range(32, 1);
        sample_data <= 16'($urandom);
        trigger_in <= 1'b1;
        wr(LEN_IDX, n);
        wr(DEFBUF_IDX, 32'h1);
        wr(CMD_IDX, 32'h00030004);
        d = 0;
        while (d[ST_DONE] !== 1'b1)
            rd(STAT_IDX);
        chk("status", 32'h200, d & 32'hf00);
        chk("beats", n / 2, 32'(beats));
        chk("data", 32'h0, 32'(bad));
        chk("notify", 32'h1, 32'(pulses));
        wr(CMD_IDX, 32'h00010000);
        rc("fault", STAT_IDX, 32'h00000a08);
        wr(LEN_IDX, 32'h00000080);
        wr(DEFBUF_IDX, 32'h1);
        wr(CMD_IDX, 32'h00010000);
        wr(CMD_IDX, 32'h00040000);
        while (host_wr_valid === 1'b1)
            @(posedge aclk);
        n = 32'(beats);
        repeat (20) @(posedge aclk);
        chk("stop", n, 32'(beats));
        chk("data", 32'h0, 32'(bad));
        end_of_test();
    end
endmodule
bind acquisition_dma_control acq_dma_properties
    #(.TMO_UNIT_CYC(TMO_UNIT_CYC)) acq_dma_properties_i (.*);
